// ===== irq_sink_model.sv
`timescale 1ns/1ps
module irq_sink_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Lines from the monitor
	input wire thermal_trip_pkg::irq_t irq,
	input wire logic trip_n,
	// Observations
	output logic [thermal_trip_pkg::NUM_IRQ-1:0][7:0] cnt,
	output logic trip_seen
);
	import thermal_trip_pkg::*;
	logic [NUM_IRQ-1:0] v;
	assign v = irq;
	////////////////////////////////////////////////////////////////
	// Every pulse is counted, so a repeated or a missing request shows.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt <= '0;
			trip_seen <= 1'b0;
		end else begin
			for (int i = 0; i < NUM_IRQ; i++) begin
				cnt[i] <= cnt[i] + 8'(v[i]);
			end
			if (!trip_n) begin
				trip_seen <= 1'b1;
			end
		end
	end
endmodule

// ===== tb_thermal_trip_monitor.sv
`timescale 1ns/1ps
module tb_thermal_trip_monitor;
	import thermal_trip_pkg::*;
	logic SYS_CLK = 1'b0;
	logic RST_N = 1'b0;
	logic [31:0] HADDR = '0;
	logic [1:0] HTRANS = 2'h0;
	logic HWRITE = 1'b0;
	logic [31:0] HWDATA = '0;
	logic [31:0] HRDATA;
	logic HREADYOUT;
	logic HRESP;
	logic [1:0][7:0] code = 16'hFFFF;
	irq_t irq;
	logic treq;
	logic [7:0] tlvl;
	logic halt;
	logic sd_n;
	logic [3:0][7:0] cnt;
	logic seen;
	logic [31:0] rd;
	int n_errors = 0;
	int total_checks = 0;
	always #5 SYS_CLK = ~SYS_CLK;
	thermal_trip_monitor u_dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .HSEL(1'b1), .HADDR(HADDR),
		.HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
		.HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SENSOR_CODE(code), .IRQ(irq),
		.THROTTLE_REQ(treq), .THROTTLE_LEVEL(tlvl), .CLOCK_HALT(halt), .OVERHEAT_SHUTDOWN_OUT_N(sd_n));
	irq_sink_model u_sb (.clk(SYS_CLK), .rst_n(RST_N), .irq(irq), .trip_n(sd_n), .cnt(cnt), .trip_seen(seen));
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// Ready is looked at mid-cycle, where the registered value is already settled.
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge SYS_CLK);
		HTRANS <= 2'h2;
		HADDR <= a;
		HWRITE <= w;
		do @(negedge SYS_CLK); while (HREADYOUT !== 1'b1);
		@(posedge SYS_CLK);
		HTRANS <= 2'h0;
		HWDATA <= d;
		do @(negedge SYS_CLK); while (HREADYOUT !== 1'b1);
		r = HRDATA;
		@(posedge SYS_CLK);
	endtask
	// Eight cycles cover the synchroniser and the output stage.
	task automatic sense(input int s, input logic [7:0] v);
		@(posedge SYS_CLK);
		code[s] <= v;
		repeat (8) @(posedge SYS_CLK);
		#1;
	endtask
	task automatic rset;
		@(posedge SYS_CLK);
		RST_N <= 1'b0;
		repeat (10) @(posedge SYS_CLK);
		RST_N <= 1'b1;
		@(posedge SYS_CLK);
		#1;
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_reg;
		chk(32'({irq, treq, tlvl, halt, sd_n, HRESP}), 32'h2);
		bus(1, OFS_SEL, 32'hFF, rd);
		bus(0, OFS_SEL, 0, rd);
		chk(rd, 32'hFF);
		bus(0, OFS_SEL + OFS_STEP, 0, rd);
		chk(rd, 32'h0);
		bus(0, 8'h7C, 0, rd);
		chk(rd, 32'h0);
		bus(0, {24'h01, OFS_SEL}, 0, rd);
		chk(rd, 32'h0);
		bus(1, {24'h01, OFS_SEL}, 32'h0, rd);
		bus(0, OFS_SEL, 0, rd);
		chk(rd, 32'hFF);
		bus(1, OFS_SEL, 32'h0, rd);
		$display("test registers done");
	endtask
	task automatic t_hot;
		bus(1, OFS_THR, 32'h5000, rd);
		bus(1, OFS_THROT, 32'h5A, rd);
		bus(1, OFS_CTRL, 32'h05, rd);
		for (int t = 0; t < NUM_IRQ; t++) begin
			bus(1, OFS_CMD + 8'(4 * t), 32'h2, rd);
			bus(1, OFS_SEL + OFS_STEP, 32'(8'h11 << t), rd);
			sense(0, 8'h40);
			chk(32'(cnt[t]), 32'h1);
			chk(32'({treq, tlvl}), 32'h15A);
			chk(32'({halt, sd_n}), 32'h1);
			sense(0, 8'h40);
			chk(32'(cnt[t]), 32'h1);
			bus(0, OFS_STATE, 0, rd);
			chk(rd, 32'h2);
			bus(0, OFS_THERMO, 0, rd);
			chk(32'(rd[7:0]), 32'h40);
			sense(0, 8'hFF);
			chk(32'(cnt[t]), 32'h2);
			chk(32'({treq, tlvl}), 32'h0);
			bus(1, OFS_CMD + 8'(4 * t), 32'h0, rd);
		end
		$display("test hot done");
	endtask
	task automatic t_aux;
		bus(1, OFS_CTRL, 32'h07, rd);
		bus(1, OFS_THR, 32'h605000, rd);
		bus(1, OFS_CMD + 8'hC, 32'h4, rd);
		bus(1, OFS_SEL + 8'h8, 32'h08, rd);
		sense(0, 8'h58);
		bus(0, OFS_STATE, 0, rd);
		chk(rd, 32'h4);
		chk(32'({cnt[3], treq, halt, sd_n}), 32'h19);
		sense(0, 8'hFF);
		$display("test aux done");
	endtask
	task automatic t_dis;
		bus(1, OFS_THR + OFS_STEP, 32'h5000, rd);
		bus(1, OFS_CTRL + OFS_STEP, 32'h04, rd);
		sense(1, 8'h40);
		bus(0, OFS_STATE, 0, rd);
		chk(32'({rd[15:0], treq}), 32'h0);
		bus(1, OFS_CTRL + OFS_STEP, 32'h05, rd);
		sense(1, 8'h40);
		bus(0, OFS_STATE, 0, rd);
		chk(32'({rd[15:0], treq}), 32'h401);
		sense(1, 8'hFF);
		$display("test disable done");
	endtask
	task automatic t_cat;
		bus(1, OFS_THR, 32'h605020, rd);
		bus(1, OFS_CTRL, 32'h13, rd);
		sense(0, 8'h10);
		chk(32'({treq, halt, sd_n}), 32'h6);
		sense(0, 8'hFF);
		chk(32'({halt, sd_n, seen}), 32'h5);
		rset();
		chk(32'({halt, sd_n}), 32'h1);
		bus(1, OFS_THR, 32'h20, rd);
		bus(1, OFS_CTRL, 32'h09, rd);
		sense(0, 8'h10);
		chk(32'({halt, sd_n}), 32'h3);
		rset();
		$display("test catastrophic done");
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		rset();
		t_reg();
		t_hot();
		t_aux();
		t_dis();
		t_cat();
		wrap_up();
	end
	// The whole run needs a few hundred cycles; this bound only cuts a hang.
	initial begin
		repeat (20000) @(posedge SYS_CLK);
		n_errors++;
		wrap_up();
	end
endmodule

// ===== thermal_trip_monitor.sv
`timescale 1ns/1ps
// Functional notes
// - Two sensors, each with its own enable bit, run independently.
// - Each sensor has catastrophic, hot and auxiliary thresholds.
// - Upward crossing of any threshold raises an enabled interrupt.
// - Catastrophic or hot trip starts memory throttling when enabled.
// - Catastrophic trip may interrupt, throttle, halt, or drive the shutdown pin.
// - Hot trip may interrupt and/or throttle, never shut down.
// - Auxiliary trip may only interrupt.
// - Trip state of every class and sensor is readable.
// - Interrupts route to control, management, error or graphics lines.
// - Each threshold has its own interrupt selection register.
// - Throttling starts in hardware with no software action.
// - Throttling applies the programmed memory throttle setting.
// - A readable thermometer value falls as temperature rises.
// - Interrupts may fire on rising or falling crossings, per selection.
// - Asserting the shutdown pin also stops internal clocks.
// - The shutdown pin stays latched until reset.
module thermal_trip_monitor #(
	parameter int NS = thermal_trip_pkg::NUM_SENSORS,
	parameter int CW = thermal_trip_pkg::CODE_W
) (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RST_N,
	// AHB-Lite slave
	input wire logic HSEL,
	input wire logic [thermal_trip_pkg::DATA_W-1:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [thermal_trip_pkg::DATA_W-1:0] HWDATA,
	input wire logic HREADY,
	output logic [thermal_trip_pkg::DATA_W-1:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	// Sensor codes
	input wire logic [NS-1:0][CW-1:0] SENSOR_CODE,
	// Interrupts, one-cycle pulses
	output thermal_trip_pkg::irq_t IRQ,
	// Memory throttling
	output logic THROTTLE_REQ,
	output logic [thermal_trip_pkg::THROT_W-1:0] THROTTLE_LEVEL,
	// Shutdown
	output logic CLOCK_HALT,
	output logic OVERHEAT_SHUTDOWN_OUT_N
);
	import thermal_trip_pkg::*;

	if (NS < 1 || NS > NUM_SENSORS || CW < 1 || CW > LANE_W) begin : g_bad_param
		$error("Register map serves one or two sensors of at most a lane of code.");
	end

	typedef struct packed {
		logic [NS-1:0][CTRL_W-1:0] ctrl;
		logic [NS-1:0][NUM_CLASSES-1:0][CW-1:0] thr;
		logic [NS-1:0][NUM_CLASSES-1:0][SEL_W-1:0] sel;
		logic [NUM_IRQ-1:0][NUM_CLASSES-1:0] cmd;
		logic [THROT_W-1:0] throt;
		logic [ADDR_W-1:0] addr;
		logic addr_ok;
		logic wr_pend;
		logic rd_pend;
		logic ready;
		logic [DATA_W-1:0] rdata;
		logic [NUM_IRQ-1:0] irq;
		logic throttle;
		logic [THROT_W-1:0] throt_out;
		logic halt;
		logic shut_n;
	} mon_state_t;

	mon_state_t s;
	mon_state_t next_s;
	logic [NS-1:0][NUM_CLASSES-1:0] trip;
	logic [NS-1:0][NUM_CLASSES-1:0] rise;
	logic [NS-1:0][NUM_CLASSES-1:0] fall;
	logic [NS-1:0][CW-1:0] reading;
	logic [NUM_IRQ-1:0] irq_cause;
	logic throttle_cause;
	logic halt_cause;
	logic pin_cause;

	function automatic logic [ADDR_W-1:0] ofs(input logic [ADDR_W-1:0] base, input int idx);
		ofs = ADDR_W'(int'(base) + int'(OFS_STEP) * idx);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	for (genvar i = 0; i < NS; i++) begin : g_sensor
		trip_detector #(.W(CW)) u_det (
			.clk(SYS_CLK),
			.rst_n(RST_N),
			.en(s.ctrl[i][CTL_EN]),
			.thr(s.thr[i]),
			.code_pin(SENSOR_CODE[i]),
			.reading(reading[i]),
			.trip(trip[i]),
			.rise(rise[i]),
			.fall(fall[i])
		);
	end

	////////////////////////////////////////////////////////////////////////////
	// Trip states already read low for a disabled sensor, so every action
	// below inherits the sensor enable without a second gate.
	always_comb begin
		irq_cause = '0;
		throttle_cause = 1'b0;
		halt_cause = 1'b0;
		pin_cause = 1'b0;
		for (int i = 0; i < NS; i++) begin
			for (int k = 0; k < NUM_CLASSES; k++) begin
				for (int t = 0; t < NUM_IRQ; t++) begin
					if (s.cmd[t][k] && ((rise[i][k] && s.sel[i][k][SEL_RISE + t]) ||
						(fall[i][k] && s.sel[i][k][SEL_FALL + t]))) begin
						irq_cause[t] = 1'b1;
					end
				end
			end
			// Throttling follows the trip level, so it ends once the die cools past every threshold whose throttling is enabled.
			// Only catastrophic and hot trips reach throttling; auxiliary never does.
			if ((trip[i][CLS_CAT] && s.ctrl[i][CTL_CAT_THR]) ||
				(trip[i][CLS_HOT] && s.ctrl[i][CTL_HOT_THR])) begin
				throttle_cause = 1'b1;
			end
			if (rise[i][CLS_CAT] && s.ctrl[i][CTL_CAT_HALT]) begin
				halt_cause = 1'b1;
			end
			if (rise[i][CLS_CAT] && s.ctrl[i][CTL_CAT_PIN]) begin
				pin_cause = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic [DATA_W-1:0] rd;
		rd = '0;
		next_s = s;
		next_s.irq = irq_cause;
		next_s.throttle = throttle_cause;
		next_s.throt_out = throttle_cause ? s.throt : THROT_RST;
		// Halting alone lets software stop the core without signalling the board.
		// The pin also stops the clocks; both stay set until reset.
		next_s.halt = s.halt || halt_cause || pin_cause;
		next_s.shut_n = s.shut_n && !pin_cause;

		for (int i = 0; i < NS; i++) begin
			if (s.addr == ofs(OFS_CTRL, i)) begin
				rd = DATA_W'(s.ctrl[i]);
			end
			if (s.addr == ofs(OFS_THR, i)) begin
				rd = DATA_W'(s.thr[i]);
			end
			for (int k = 0; k < NUM_CLASSES; k++) begin
				if (s.addr == ofs(OFS_SEL, i * NUM_CLASSES + k)) begin
					rd = DATA_W'(s.sel[i][k]);
				end
			end
		end
		for (int i = 0; i < NS; i++) begin
			if (s.addr == OFS_STATE) begin
				rd[i * LANE_W +: NUM_CLASSES] = trip[i];
			end
			if (s.addr == OFS_THERMO) begin
				rd[i * LANE_W +: CW] = reading[i];
			end
		end
		for (int t = 0; t < NUM_IRQ; t++) begin
			if (s.addr == ofs(OFS_CMD, t)) begin
				rd = DATA_W'(s.cmd[t]);
			end
		end
		if (s.addr == OFS_THROT) begin
			rd = DATA_W'(s.throt);
		end
		if (!s.addr_ok) begin
			rd = '0;
		end

		// Reads take one wait state so a write just before is always seen.
		next_s.wr_pend = 1'b0;
		next_s.rd_pend = 1'b0;
		if (s.rd_pend) begin
			next_s.rdata = rd;
			next_s.ready = 1'b1;
		end
		if (s.wr_pend && s.addr_ok) begin
			for (int i = 0; i < NS; i++) begin
				if (s.addr == ofs(OFS_CTRL, i)) begin
					next_s.ctrl[i] = HWDATA[CTRL_W-1:0];
				end
				if (s.addr == ofs(OFS_THR, i)) begin
					next_s.thr[i] = HWDATA[NUM_CLASSES*CW-1:0];
				end
				for (int k = 0; k < NUM_CLASSES; k++) begin
					if (s.addr == ofs(OFS_SEL, i * NUM_CLASSES + k)) begin
						next_s.sel[i][k] = HWDATA[SEL_W-1:0];
					end
				end
			end
			for (int t = 0; t < NUM_IRQ; t++) begin
				if (s.addr == ofs(OFS_CMD, t)) begin
					next_s.cmd[t] = HWDATA[NUM_CLASSES-1:0];
				end
			end
			if (s.addr == OFS_THROT) begin
				next_s.throt = HWDATA[THROT_W-1:0];
			end
		end
		// An access with upper address bits set still answers OKAY, but it reads zero
		// and writes nothing, so a stray pointer cannot reprogram a threshold.
		if (HSEL && HREADY && HTRANS[HTRANS_ACT]) begin
			next_s.addr = HADDR[ADDR_W-1:0];
			next_s.addr_ok = (HADDR[DATA_W-1:ADDR_W] == '0);
			next_s.wr_pend = HWRITE;
			next_s.rd_pend = !HWRITE;
			next_s.ready = HWRITE;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			s <= '0;
			s.ctrl <= {NS{CTRL_RST}};
			s.thr <= {(NS * NUM_CLASSES){THR_RST}};
			s.sel <= {(NS * NUM_CLASSES){SEL_RST}};
			s.cmd <= {NUM_IRQ{CMD_RST}};
			s.throt <= THROT_RST;
			s.throt_out <= THROT_RST;
			s.ready <= 1'b1;
			s.shut_n <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign HRDATA = s.rdata;
	assign HREADYOUT = s.ready;
	assign HRESP = 1'b0;
	assign IRQ = irq_t'(s.irq);
	assign THROTTLE_REQ = s.throttle;
	assign THROTTLE_LEVEL = s.throt_out;
	assign CLOCK_HALT = s.halt;
	assign OVERHEAT_SHUTDOWN_OUT_N = s.shut_n;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RST_N);

	sequence rd_req;
		HSEL && HREADY && HTRANS[HTRANS_ACT] && !HWRITE;
	endsequence
	sequence rd_data;
		!HREADYOUT ##1 HREADYOUT;
	endsequence
	sequence wr_req;
		HSEL && HREADY && HTRANS[HTRANS_ACT] && HWRITE;
	endsequence

	a_read_wait: assert property (rd_req |=> rd_data)
		else $error("Read did not take exactly one wait state.");
	a_irq_route: assert property ((irq_cause != '0) |=> (IRQ == $past(irq_cause)))
		else $error("Interrupt lines do not match the crossing.");
	a_irq_quiet: assert property ((irq_cause == '0) |=> (IRQ == '0))
		else $error("Interrupt raised without a selected crossing.");
	a_throttle_req: assert property (throttle_cause |=> THROTTLE_REQ && THROTTLE_LEVEL == $past(s.throt))
		else $error("Throttling did not start with the programmed setting.");
	a_throttle_stop: assert property (!throttle_cause |=> !THROTTLE_REQ)
		else $error("Throttling requested without an enabled trip.");
	a_shut_cause: assert property ($fell(OVERHEAT_SHUTDOWN_OUT_N) |-> $past(pin_cause))
		else $error("Shutdown pin asserted without a catastrophic trip.");
	a_halt_entry: assert property (halt_cause |=> CLOCK_HALT)
		else $error("Catastrophic halt did not stop the clocks.");
	a_trip_held: assert property (!OVERHEAT_SHUTDOWN_OUT_N |=> !OVERHEAT_SHUTDOWN_OUT_N)
		else $error("Shutdown pin released before reset.");
	a_trip_halts: assert property (!OVERHEAT_SHUTDOWN_OUT_N |-> CLOCK_HALT)
		else $error("Shutdown pin asserted with clocks still running.");

	// Halting and the pin are the only shutdown paths, and both come from a catastrophic rise.
	a_halt_source: assert property ($rose(CLOCK_HALT) |-> ($past(halt_cause) || $past(pin_cause)))
		else $error("Clocks halted without a catastrophic trip.");
	a_halt_held: assert property (CLOCK_HALT |=> CLOCK_HALT)
		else $error("Clock halt released before reset.");
	a_level_idle: assert property (!THROTTLE_REQ |-> THROTTLE_LEVEL == THROT_RST)
		else $error("Throttle setting shown while not throttling.");
	// Read data must stand until the next read, since the master may take it late.
	a_rdata_hold: assert property (!s.rd_pend |=> $stable(HRDATA))
		else $error("Read data changed without a read.");
	a_wait_single: assert property (!HREADYOUT |=> HREADYOUT)
		else $error("Wait state lasted more than one cycle.");
	a_write_ready: assert property (wr_req |=> HREADYOUT)
		else $error("Write inserted a wait state.");
endmodule

// ===== thermal_trip_pkg.sv
package thermal_trip_pkg;
	localparam int NUM_SENSORS = 2;
	localparam int CODE_W = 8;
	localparam int NUM_CLASSES = 3;
	localparam int NUM_IRQ = 4;
	localparam int CLS_CAT = 0;
	localparam int CLS_HOT = 1;
	localparam int CLS_AUX = 2;
	localparam int CTRL_W = 5;
	localparam int CTL_EN = 0;
	localparam int CTL_CAT_THR = 1;
	localparam int CTL_HOT_THR = 2;
	localparam int CTL_CAT_HALT = 3;
	localparam int CTL_CAT_PIN = 4;
	localparam int SEL_W = 8;
	localparam int SEL_RISE = 0;
	localparam int SEL_FALL = 4;
	localparam int THROT_W = 8;
	localparam int LANE_W = 8;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int HTRANS_ACT = 1;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_THR = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_STATE = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_THERMO = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_SEL = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_CMD = 8'h30;
	localparam logic [ADDR_W-1:0] OFS_THROT = 8'h40;
	localparam logic [ADDR_W-1:0] OFS_STEP = 8'h04;
	localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
	localparam logic [CODE_W-1:0] THR_RST = 8'h00;
	localparam logic [SEL_W-1:0] SEL_RST = 8'h00;
	localparam logic [NUM_CLASSES-1:0] CMD_RST = 3'h0;
	localparam logic [THROT_W-1:0] THROT_RST = 8'h00;

	typedef struct packed {
		logic gfx;
		logic sci;
		logic smi;
		logic serr;
	} irq_t;
endpackage

// ===== trip_detector.sv
`timescale 1ns/1ps
module trip_detector #(
	parameter int W = thermal_trip_pkg::CODE_W
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control
	input wire logic en,
	input wire logic [thermal_trip_pkg::NUM_CLASSES-1:0][W-1:0] thr,
	// Sensor code from the analog side
	input wire logic [W-1:0] code_pin,
	// Results
	output logic [W-1:0] reading,
	output logic [thermal_trip_pkg::NUM_CLASSES-1:0] trip,
	output logic [thermal_trip_pkg::NUM_CLASSES-1:0] rise,
	output logic [thermal_trip_pkg::NUM_CLASSES-1:0] fall
);
	import thermal_trip_pkg::*;

	if (W < 1 || W > LANE_W) begin : g_bad_width
		$error("Code width does not fit a status lane.");
	end

	typedef struct packed {
		logic [W-1:0] sync1;
		logic [W-1:0] sync2;
		logic [W-1:0] reading;
		logic [NUM_CLASSES-1:0] trip;
		logic [NUM_CLASSES-1:0] rise;
		logic [NUM_CLASSES-1:0] fall;
	} det_state_t;

	det_state_t s;
	det_state_t next_s;

	////////////////////////////////////////////////////////////////////////////
	// The code is synchronised bit by bit; a code that moves mid-sample may be
	// seen one cycle late, which is harmless for a slow thermal trend.
	always_comb begin
		next_s = s;
		next_s.sync1 = code_pin;
		next_s.sync2 = s.sync1;
		if (en) begin
			next_s.reading = s.sync2;
		end
		for (int k = 0; k < NUM_CLASSES; k++) begin
			// A lower code means a hotter die, so a trip is a code at or below the threshold.
			next_s.trip[k] = en && (s.sync2 <= thr[k]);
			next_s.rise[k] = next_s.trip[k] && !s.trip[k];
			next_s.fall[k] = en && !next_s.trip[k] && s.trip[k];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign reading = s.reading;
	assign trip = s.trip;
	assign rise = s.rise;
	assign fall = s.fall;

	////////////////////////////////////////////////////////////////////////////
	a_rise_once: assert property (@(posedge clk) disable iff (!rst_n) (rise != '0) |=> ((rise & $past(rise)) == '0))
		else $error("A crossing was reported twice.");
	a_sensor_off: assert property (@(posedge clk) disable iff (!rst_n) !en |=> (trip == '0 && rise == '0 && fall == '0))
		else $error("A disabled sensor produced a trip.");
	a_reading_track: assert property (@(posedge clk) disable iff (!rst_n) en [*3] |=> reading == $past(code_pin, 3))
		else $error("Thermometer reading does not follow the sensor.");
endmodule
